// file: dv/ocss_osc_model.sv
`timescale 1ns/1ns
module ocss_osc_model #(
    parameter int IC_H  = 24,
    parameter int RC_H  = 36,
    parameter int XT_H  = 52,
    parameter int BUS_H = 16
) (
    input  wire logic ic_en_in,
    input  wire logic rc_en_in,
    input  wire logic xt_en_in,
    output logic      ic_clk_out,
    output logic      rc_clk_out,
    output logic      xt_clk_out,
    output logic      amp_out,
    output logic      bus_clk_out
);
    // a disabled oscillator rests low
    initial {ic_clk_out, rc_clk_out, xt_clk_out, bus_clk_out} = 4'h0;
    always #IC_H ic_clk_out = ic_en_in & ~ic_clk_out;
    always #RC_H rc_clk_out = rc_en_in & ~rc_clk_out;
    always #XT_H xt_clk_out = xt_en_in & ~xt_clk_out;
    always #BUS_H bus_clk_out = ~bus_clk_out;
    assign amp_out = xt_en_in & ~xt_clk_out;
endmodule

// file: dv/testbench.sv
`timescale 1ns/1ns
module testbench;
    import ocss_pkg::*;
    typedef struct {
        logic        rd;
        logic [31:0] d;
        logic        e;
    } ocss_note_t;
    localparam int WIN = 1000;
    localparam int IC_H = 24, RC_H = 36, XT_H = 52, BUS_H = 16;
    logic        core_clk_in = 1'b0, arst_n_in = 1'b0;
    logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
    logic [17:0] paddr_in = 18'h0;
    logic [31:0] pwdata_in = 32'h0, prdata_out;
    logic        pready_out, pslverr_out;
    logic [7:0]  option_byte_in = 8'h00;
    logic        internal_osc_clock_in, rc_osc_clock_in;
    logic        crystal_osc_clock_in, crystal_amp_in, bus_clock_in;
    logic        osc_enable_from_sysint_in = 1'b1, stop_mode_in = 1'b0;
    logic        wait_mode_in = 1'b0, break_in = 1'b0;
    logic        main_ref_clock_out, pll_ref_clock_out;
    logic        timebase_ref_clock_out, watchdog_ref_clock_out;
    logic        osc_output_pin_out, internal_osc_en_out;
    logic        rc_osc_en_out, crystal_osc_en_out;
    int          miscompares = 0, cmp_count = 0;
    int          cnt[5];
    ocss_note_t  notes[$];
    ocss_note_t  nt;
    always #2 core_clk_in = ~core_clk_in;
    ocss_top #(.ADDR_W(18)) u_dut (
        .core_clk_in(core_clk_in), .arst_n_in(arst_n_in),
        .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out),
        .option_byte_in(option_byte_in),
        .internal_osc_clock_in(internal_osc_clock_in),
        .rc_osc_clock_in(rc_osc_clock_in),
        .crystal_osc_clock_in(crystal_osc_clock_in),
        .crystal_amp_in(crystal_amp_in), .bus_clock_in(bus_clock_in),
        .osc_enable_from_sysint_in(osc_enable_from_sysint_in),
        .stop_mode_in(stop_mode_in), .wait_mode_in(wait_mode_in),
        .break_in(break_in), .main_ref_clock_out(main_ref_clock_out),
        .pll_ref_clock_out(pll_ref_clock_out),
        .timebase_ref_clock_out(timebase_ref_clock_out),
        .watchdog_ref_clock_out(watchdog_ref_clock_out),
        .osc_output_pin_out(osc_output_pin_out),
        .internal_osc_en_out(internal_osc_en_out),
        .rc_osc_en_out(rc_osc_en_out),
        .crystal_osc_en_out(crystal_osc_en_out));
    ocss_osc_model #(.IC_H(IC_H), .RC_H(RC_H), .XT_H(XT_H), .BUS_H(BUS_H))
    u_osc (.ic_en_in(internal_osc_en_out), .rc_en_in(rc_osc_en_out),
        .xt_en_in(crystal_osc_en_out), .ic_clk_out(internal_osc_clock_in),
        .rc_clk_out(rc_osc_clock_in), .xt_clk_out(crystal_osc_clock_in),
        .amp_out(crystal_amp_in), .bus_clk_out(bus_clock_in));
    task automatic stop_test;
        $display("compares %0d mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk_val(input string nm, input logic [31:0] e, s);
        cmp_count++;
        if (s !== e) begin
            miscompares++;
            $display("FAIL %s exp %h got %h", nm, e, s);
        end
    endtask
    task automatic chk_bit(input string nm, input logic e, s);
        chk_val(nm, {31'h0, e}, {31'h0, s});
    endtask
    task automatic chk_cnt(input string nm, input int e, s);
        cmp_count++;
        if (s < e - 2 || s > e + 2) begin
            miscompares++;
            $display("FAIL %s exp %0d got %0d", nm, e, s);
        end
    endtask
    function automatic int ex(input int h);
        return WIN * 2 / h;
    endfunction
    function automatic int src_cnt(input logic [1:0] m);
        return m == MAIN_INTERNAL_OSC_CLOCK ? ex(IC_H) : m == MAIN_RC ? ex(RC_H) :
            m == MAIN_XTAL ? ex(XT_H) : 0;
    endfunction
    function automatic int tb_cnt(input logic [1:0] m, t);
        return t == TB_INTERNAL_OSC_CLOCK ? ex(IC_H) :
            (t == TB_RC && m == MAIN_RC) ? ex(RC_H) :
            (t == TB_XTAL && m == MAIN_XTAL) ? ex(XT_H) : 0;
    endfunction
    // one apb transfer, its expected answer queued for the monitor
    task automatic apb(input logic wr, input logic [17:0] a,
        input logic [31:0] d, e, input logic er);
        int n;
        notes.push_back('{~wr, e, er});
        @(posedge core_clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge core_clk_in);
        penable_in <= 1'b1;
        n = 0;
        do begin
            @(posedge core_clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 20);
        psel_in <= 1'b0;
        penable_in <= 1'b0;
        if (pready_out !== 1'b1) begin
            miscompares++;
            stop_test();
        end
    endtask
    always @(posedge core_clk_in) begin
        if (pready_out === 1'b1) begin
            if (notes.size() == 0) begin
                miscompares++;
                $display("FAIL apb_note exp 1 got 0");
            end else begin
                nt = notes.pop_front();
                chk_bit("pslverr", nt.e, pslverr_out);
                if (nt.rd) chk_val("prdata", nt.d, prdata_out);
            end
        end
    end
    // rising edges of main, pll, timebase, watchdog and pin outputs
    task automatic measure;
        logic [4:0] prv, cur;
        repeat (12) @(posedge core_clk_in);
        cnt = '{default: 0};
        prv = 5'h00;
        repeat (WIN) begin
            @(posedge core_clk_in);
            cur = {main_ref_clock_out, pll_ref_clock_out,
                timebase_ref_clock_out, watchdog_ref_clock_out,
                osc_output_pin_out};
            chk_bit("known_out", 1'b0, $isunknown(cur));
            for (int i = 0; i < 5; i++) cnt[i] += int'(cur[i] & ~prv[i]);
            prv = cur;
        end
    endtask
    initial begin
        logic [1:0]  m;
        logic [31:0] r;
        logic [7:0]  sc[3];
        sc = '{8'h02, 8'h0a, 8'h12};
        void'($urandom(20004));
        for (int s = 0; s < 4; s++) begin
            m = 2'(s);
            arst_n_in <= 1'b0;
            option_byte_in <= {6'h00, m};
            repeat (10) @(posedge core_clk_in);
            arst_n_in <= 1'b1;
            repeat (3) @(posedge core_clk_in);
            option_byte_in <= {6'h3f, ~m};
            apb(1'b0, 18'(CFG2_ADDR), 32'h0, 32'(CFG2_RST), 1'b0);
            apb(1'b0, 18'(OPT_ADDR), 32'h0, 32'(m), 1'b0);
            r = 32'(m) | (32'h1 << ST_IC_EN)
                | (32'(m == MAIN_RC) << ST_RC_EN)
                | (32'(m == MAIN_XTAL) << ST_XT_EN);
            apb(1'b0, 18'(STAT_ADDR), 32'h0, r, 1'b0);
            chk_bit("ic_en", 1'b1, internal_osc_en_out);
            chk_bit("rc_en", m == MAIN_RC, rc_osc_en_out);
            chk_bit("xt_en", m == MAIN_XTAL, crystal_osc_en_out);
            for (int t = 0; t < 4; t++) begin
                apb(1'b1, 18'(CFG2_ADDR), 32'(t), 32'h0, 1'b0);
                measure();
                chk_cnt("main", src_cnt(m), cnt[4]);
                chk_cnt("pll", src_cnt(m), cnt[3]);
                chk_cnt("tbase", tb_cnt(m, 2'(t)), cnt[2]);
                chk_cnt("wdog", ex(IC_H), cnt[1]);
                if (m != MAIN_NONE) chk_cnt("opin",
                    m == MAIN_XTAL ? ex(XT_H) : ex(BUS_H), cnt[0]);
            end
        end
        r = $urandom();
        apb(1'b1, 18'(CFG2_ADDR), r, 32'h0, 1'b0);
        apb(1'b0, 18'(CFG2_ADDR), 32'h0, r & 32'(CFG2_MASK), 1'b0);
        apb(1'b1, 18'(OPT_ADDR), r, 32'h0, 1'b0);
        apb(1'b0, 18'(OPT_ADDR), 32'h0, 32'(MAIN_XTAL), 1'b0);
        apb(1'b0, 18'h00100, 32'h0, 32'h0, 1'b1);
        apb(1'b1, 18'h00100, r, 32'h0, 1'b1);
        apb(1'b1, 18'(CFG2_ADDR), 32'(TB_XTAL), 32'h0, 1'b0);
        for (int k = 1; k < 3; k++) begin
            {break_in, wait_mode_in} <= 2'(k);
            measure();
            chk_cnt("main_lp", ex(XT_H), cnt[4]);
            chk_cnt("tbase_lp", ex(XT_H), cnt[2]);
        end
        {break_in, wait_mode_in} <= 2'h0;
        for (int k = 0; k < 3; k++) begin
            apb(1'b1, 18'(CFG2_ADDR), 32'(sc[k]), 32'h0, 1'b0);
            stop_mode_in <= 1'b1;
            measure();
            chk_bit("xt_stop", sc[k][3], crystal_osc_en_out);
            chk_bit("ic_stop", ~sc[k][4], internal_osc_en_out);
            chk_cnt("main_stop", sc[k][3] ? ex(XT_H) : 0, cnt[4]);
            chk_cnt("wdog_stop", sc[k][4] ? 0 : ex(IC_H), cnt[1]);
            r = 32'(MAIN_XTAL) | (32'h1 << ST_STOP)
                | ((sc[k][4] ? 32'h0 : 32'h1) << ST_IC_EN)
                | (32'(sc[k][3]) << ST_XT_EN);
            apb(1'b0, 18'(STAT_ADDR), 32'h0, r, 1'b0);
            stop_mode_in <= 1'b0;
            repeat (20) @(posedge core_clk_in);
        end
        osc_enable_from_sysint_in <= 1'b0;
        repeat (4) @(posedge core_clk_in);
        chk_bit("ic_sys", 1'b0, internal_osc_en_out);
        chk_bit("xt_sys", 1'b0, crystal_osc_en_out);
        osc_enable_from_sysint_in <= 1'b1;
        repeat (4) @(posedge core_clk_in);
        chk_bit("xt_sys_on", 1'b1, crystal_osc_en_out);
        stop_test();
    end
endmodule

// file: verilog/ocss_pkg.sv
package ocss_pkg;
    localparam int          DATA_W        = 32;
    localparam int          ADDR_W_MIN    = 18;
    // register indices as printed, byte address is four times the index
    localparam int          CFG2_IDX      = 32'h0000001d;
    localparam int          OPT_IDX       = 32'h0000ffcf;
    localparam int          STAT_IDX      = 32'h0000001e;
    localparam int          CFG2_ADDR     = CFG2_IDX * 4;
    localparam int          OPT_ADDR      = OPT_IDX * 4;
    localparam int          STAT_ADDR     = STAT_IDX * 4;
    localparam logic [7:0]  CFG2_RST      = 8'h00;
    localparam logic [7:0]  CFG2_MASK     = 8'h1f;
    localparam logic [7:0]  OPT_RST       = 8'h00;
    // config_register_two fields
    localparam int          TB_SEL_LO     = 0;
    localparam int          TB_SEL_HI     = 1;
    localparam int          STOP_RC_KEEP  = 2;
    localparam int          STOP_XT_KEEP  = 3;
    localparam int          STOP_IC_DIS   = 4;
    // option_byte fields
    localparam int          MAIN_SEL_LO   = 0;
    localparam int          MAIN_SEL_HI   = 1;
    // status fields
    localparam int          ST_IC_EN      = 2;
    localparam int          ST_RC_EN      = 3;
    localparam int          ST_XT_EN      = 4;
    localparam int          ST_STOP       = 5;
    // main source encodings
    localparam logic [1:0]  MAIN_NONE     = 2'h0;
    localparam logic [1:0]  MAIN_INTERNAL_OSC_CLOCK     = 2'h1;
    localparam logic [1:0]  MAIN_RC       = 2'h2;
    localparam logic [1:0]  MAIN_XTAL     = 2'h3;
    // timebase source encodings
    localparam logic [1:0]  TB_INTERNAL_OSC_CLOCK       = 2'h0;
    localparam logic [1:0]  TB_RC         = 2'h1;
    localparam logic [1:0]  TB_XTAL       = 2'h2;
    // synchroniser bank bit positions
    localparam int          SYNC_N        = 5;
    localparam int          SY_INTERNAL_OSC_CLOCK       = 0;
    localparam int          SY_RC         = 1;
    localparam int          SY_XTAL       = 2;
    localparam int          SY_BUS        = 3;
    localparam int          SY_AMP        = 4;
endpackage

// file: verilog/ocss_top.sv
// The APB slave port was decided locally.
`timescale 1ns/1ns
module ocss_top #(
    parameter int ADDR_W = 18
) (
    input  wire logic                        core_clk_in,
    input  wire logic                        arst_n_in,
    input  wire logic                        psel_in,
    input  wire logic                        penable_in,
    input  wire logic                        pwrite_in,
    input  wire logic [ADDR_W-1:0]           paddr_in,
    input  wire logic [ocss_pkg::DATA_W-1:0] pwdata_in,
    output logic      [ocss_pkg::DATA_W-1:0] prdata_out,
    output logic                             pready_out,
    output logic                             pslverr_out,
    input  wire logic [7:0]                  option_byte_in,
    input  wire logic                        internal_osc_clock_in,
    input  wire logic                        rc_osc_clock_in,
    input  wire logic                        crystal_osc_clock_in,
    input  wire logic                        crystal_amp_in,
    input  wire logic                        bus_clock_in,
    input  wire logic                        osc_enable_from_sysint_in,
    input  wire logic                        stop_mode_in,
    input  wire logic                        wait_mode_in,
    input  wire logic                        break_in,
    output logic                             main_ref_clock_out,
    output logic                             pll_ref_clock_out,
    output logic                             timebase_ref_clock_out,
    output logic                             watchdog_ref_clock_out,
    output logic                             osc_output_pin_out,
    output logic                             internal_osc_en_out,
    output logic                             rc_osc_en_out,
    output logic                             crystal_osc_en_out
);
    import ocss_pkg::*;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!arst_n_in);

    if (ADDR_W < ADDR_W_MIN) begin : g_chk
        $error("ADDR_W too small for the register map");
    end

    logic [SYNC_N-1:0] raw;
    logic [SYNC_N-1:0] s1_q;
    logic [SYNC_N-1:0] s2_q;
    logic [SYNC_N-1:0] s3_q;
    logic [SYNC_N-1:0] filt_q;
    logic [7:0]        cfg_q;
    logic [7:0]        opt_q;
    logic [1:0]        main_sel_q;
    logic              cap_done_q;
    logic              stop_prev_q;
    logic              lat_rc_keep_q;
    logic              lat_xt_keep_q;
    logic              lat_ic_dis_q;
    logic              stop_entry;
    logic              rc_keep;
    logic              xt_keep;
    logic              ic_dis;
    logic              ic_en_d;
    logic              rc_en_d;
    logic              xt_en_d;
    logic              main_d;
    logic              tb_d;
    logic              acc;
    logic              hit_cfg;
    logic              hit_opt;
    logic              hit_stat;
    logic [7:0]        stat;

    // wait and break leave the oscillators alone
    assign raw = {crystal_amp_in, bus_clock_in, crystal_osc_clock_in,
                  rc_osc_clock_in, internal_osc_clock_in};

    // three stage sampling, a change counts once stages two and three agree
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            s1_q   <= '0;
            s2_q   <= '0;
            s3_q   <= '0;
            filt_q <= '0;
        end else begin
            s1_q   <= raw;
            s2_q   <= s1_q;
            s3_q   <= s2_q;
            filt_q <= (filt_q & (s2_q ^ s3_q)) | (s3_q & ~(s2_q ^ s3_q));
        end
    end

    // main source captured at the first edge after reset release
    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cap_done_q <= 1'b0;
            opt_q      <= OPT_RST;
            main_sel_q <= MAIN_NONE;
        end else if (!cap_done_q) begin
            cap_done_q <= 1'b1;
            opt_q      <= option_byte_in;
            main_sel_q <= option_byte_in[MAIN_SEL_HI:MAIN_SEL_LO];
        end
    end

    // stop control bits are taken as they stand on stop entry
    assign stop_entry = stop_mode_in && !stop_prev_q;
    assign rc_keep = stop_entry ? cfg_q[STOP_RC_KEEP] : lat_rc_keep_q;
    assign xt_keep = stop_entry ? cfg_q[STOP_XT_KEEP] : lat_xt_keep_q;
    assign ic_dis  = stop_entry ? cfg_q[STOP_IC_DIS]  : lat_ic_dis_q;

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            stop_prev_q   <= 1'b0;
            lat_rc_keep_q <= 1'b0;
            lat_xt_keep_q <= 1'b0;
            lat_ic_dis_q  <= 1'b0;
        end else begin
            stop_prev_q   <= stop_mode_in;
            lat_rc_keep_q <= rc_keep;
            lat_xt_keep_q <= xt_keep;
            lat_ic_dis_q  <= ic_dis;
        end
    end

    always_comb begin
        ic_en_d = osc_enable_from_sysint_in
                  && !(stop_mode_in && ic_dis);
        rc_en_d = osc_enable_from_sysint_in && (main_sel_q == MAIN_RC)
                  && !(stop_mode_in && !rc_keep);
        xt_en_d = osc_enable_from_sysint_in && (main_sel_q == MAIN_XTAL)
                  && !(stop_mode_in && !xt_keep);
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            internal_osc_en_out <= 1'b0;
            rc_osc_en_out       <= 1'b0;
            crystal_osc_en_out  <= 1'b0;
        end else begin
            internal_osc_en_out <= ic_en_d;
            rc_osc_en_out       <= rc_en_d;
            crystal_osc_en_out  <= xt_en_d;
        end
    end

    // clock routing
    always_comb begin
        case (main_sel_q)
            MAIN_INTERNAL_OSC_CLOCK: main_d = filt_q[SY_INTERNAL_OSC_CLOCK] && internal_osc_en_out;
            MAIN_RC:   main_d = filt_q[SY_RC] && rc_osc_en_out;
            MAIN_XTAL: main_d = filt_q[SY_XTAL] && crystal_osc_en_out;
            default:   main_d = 1'b0;
        endcase
        case (cfg_q[TB_SEL_HI:TB_SEL_LO])
            TB_INTERNAL_OSC_CLOCK: tb_d = filt_q[SY_INTERNAL_OSC_CLOCK] && internal_osc_en_out;
            TB_RC:   tb_d = filt_q[SY_RC] && rc_osc_en_out
                            && (main_sel_q == MAIN_RC);
            TB_XTAL: tb_d = filt_q[SY_XTAL] && crystal_osc_en_out
                            && (main_sel_q == MAIN_XTAL);
            default: tb_d = 1'b0;
        endcase
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            main_ref_clock_out     <= 1'b0;
            pll_ref_clock_out      <= 1'b0;
            timebase_ref_clock_out <= 1'b0;
            watchdog_ref_clock_out <= 1'b0;
            osc_output_pin_out     <= 1'b0;
        end else begin
            main_ref_clock_out     <= main_d;
            pll_ref_clock_out      <= main_d;
            timebase_ref_clock_out <= tb_d;
            watchdog_ref_clock_out <= filt_q[SY_INTERNAL_OSC_CLOCK]
                                      && internal_osc_en_out;
            osc_output_pin_out     <= (main_sel_q == MAIN_XTAL)
                                      ? filt_q[SY_AMP]
                                      : filt_q[SY_BUS];
        end
    end

    // apb slave, one wait state
    assign acc      = psel_in && penable_in && !pready_out;
    assign hit_cfg  = paddr_in == ADDR_W'(CFG2_ADDR);
    assign hit_opt  = paddr_in == ADDR_W'(OPT_ADDR);
    assign hit_stat = paddr_in == ADDR_W'(STAT_ADDR);
    assign stat = {2'h0, stop_mode_in, crystal_osc_en_out, rc_osc_en_out,
                   internal_osc_en_out, main_sel_q};

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= '0;
        end else begin
            pready_out  <= acc;
            pslverr_out <= acc && !(hit_cfg || hit_opt || hit_stat);
            if (acc && !pwrite_in) begin
                if (hit_cfg) begin
                    prdata_out <= {24'h000000, cfg_q};
                end else if (hit_opt) begin
                    prdata_out <= {24'h000000, opt_q};
                end else if (hit_stat) begin
                    prdata_out <= {24'h000000, stat};
                end else begin
                    prdata_out <= '0;
                end
            end else begin
                prdata_out <= '0;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            cfg_q <= CFG2_RST;
        end else if (psel_in && penable_in && pready_out && pwrite_in
                     && hit_cfg) begin
            cfg_q <= pwdata_in[7:0] & CFG2_MASK;
        end
    end

    sequence s_stop_enter;
        $rose(stop_mode_in) && osc_enable_from_sysint_in;
    endsequence

    sequence s_stop_hold;
        stop_mode_in && stop_prev_q;
    endsequence

    a_rc_xtal_excl: assert property (
        !(rc_osc_en_out && crystal_osc_en_out))
        else $error("rc and crystal enabled together");
    a_pll_copy_main: assert property (
        pll_ref_clock_out == main_ref_clock_out)
        else $error("pll reference differs from main clock");
    a_sel_held: assert property (
        cap_done_q |=> $stable(main_sel_q))
        else $error("main source changed while running");
    a_opt_held: assert property (
        cap_done_q |=> $stable(opt_q))
        else $error("option copy changed while running");
    a_sysint_gate: assert property (
        !osc_enable_from_sysint_in |=> !internal_osc_en_out
        && !rc_osc_en_out && !crystal_osc_en_out)
        else $error("oscillator on without system enable");
    a_internal_osc_clock_stop_run: assert property (
        s_stop_enter ##0 !cfg_q[STOP_IC_DIS] |=> internal_osc_en_out)
        else $error("internal oscillator stopped in stop");
    a_internal_osc_clock_stop_off: assert property (
        s_stop_enter ##0 cfg_q[STOP_IC_DIS] |=> !internal_osc_en_out)
        else $error("internal oscillator ran in stop");
    a_internal_osc_clock_runs: assert property (
        osc_enable_from_sysint_in && !stop_mode_in
        |=> internal_osc_en_out)
        else $error("internal oscillator not running");
    a_xtal_stop_off: assert property (
        s_stop_enter ##0 !cfg_q[STOP_XT_KEEP]
        |=> !crystal_osc_en_out)
        else $error("crystal kept running in stop");
    a_xtal_stop_keep: assert property (
        s_stop_enter ##0 cfg_q[STOP_XT_KEEP] && main_sel_q == MAIN_XTAL
        |=> crystal_osc_en_out)
        else $error("crystal stopped despite keep bit");
    a_rc_stop_off: assert property (
        s_stop_enter ##0 !cfg_q[STOP_RC_KEEP]
        |=> !rc_osc_en_out)
        else $error("rc kept running in stop");
    a_rc_stop_keep: assert property (
        s_stop_enter ##0 cfg_q[STOP_RC_KEEP] && main_sel_q == MAIN_RC
        |=> rc_osc_en_out)
        else $error("rc stopped despite keep bit");
    a_stop_hold_off: assert property (
        s_stop_hold ##0 !lat_xt_keep_q && !lat_rc_keep_q
        |=> !crystal_osc_en_out && !rc_osc_en_out)
        else $error("oscillator restarted during stop");
    a_wait_no_effect: assert property (
        wait_mode_in && !stop_mode_in && osc_enable_from_sysint_in
        |=> internal_osc_en_out
        && rc_osc_en_out == ($past(main_sel_q) == MAIN_RC)
        && crystal_osc_en_out == ($past(main_sel_q) == MAIN_XTAL))
        else $error("oscillator stopped in wait");
    a_main_none: assert property (
        main_sel_q == MAIN_NONE |=> !main_ref_clock_out)
        else $error("main clock runs with no source");
    a_main_internal_osc_clock: assert property (
        main_sel_q == MAIN_INTERNAL_OSC_CLOCK |=> main_ref_clock_out
        == ($past(filt_q[SY_INTERNAL_OSC_CLOCK]) && $past(internal_osc_en_out)))
        else $error("main clock not from internal oscillator");
    a_tb_internal_osc_clock: assert property (
        cfg_q[TB_SEL_HI:TB_SEL_LO] == TB_INTERNAL_OSC_CLOCK |=> timebase_ref_clock_out
        == ($past(filt_q[SY_INTERNAL_OSC_CLOCK]) && $past(internal_osc_en_out)))
        else $error("timebase not from internal oscillator");
    a_tb_unused: assert property (
        &cfg_q[TB_SEL_HI:TB_SEL_LO] |=> !timebase_ref_clock_out)
        else $error("timebase runs on unused code");
    a_tb_rc_gate: assert property (
        main_sel_q != MAIN_RC && cfg_q[TB_SEL_HI:TB_SEL_LO] == TB_RC
        |=> !timebase_ref_clock_out)
        else $error("rc reached timebase while not main source");
    a_tb_xtal_gate: assert property (
        main_sel_q != MAIN_XTAL && cfg_q[TB_SEL_HI:TB_SEL_LO] == TB_XTAL
        |=> !timebase_ref_clock_out)
        else $error("crystal reached timebase while not main source");
    a_wdog_internal_osc_clock: assert property (
        watchdog_ref_clock_out |-> $past(filt_q[SY_INTERNAL_OSC_CLOCK]))
        else $error("watchdog clock not from internal oscillator");
    a_break_main: assert property (
        break_in && !stop_mode_in && main_sel_q == MAIN_XTAL
        && crystal_osc_en_out |=> main_ref_clock_out == $past(filt_q[SY_XTAL]))
        else $error("main clock interrupted in break");
    a_pin_xtal: assert property (
        main_sel_q == MAIN_XTAL |=> osc_output_pin_out
        == $past(filt_q[SY_AMP]))
        else $error("output pin not amplifier output");
    a_pin_bus: assert property (
        main_sel_q != MAIN_XTAL |=> osc_output_pin_out
        == $past(filt_q[SY_BUS]))
        else $error("output pin not bus clock");
    a_cfg_write: assert property (
        psel_in && penable_in && pready_out && pwrite_in && hit_cfg
        |=> cfg_q == (CFG2_MASK & 8'($past(pwdata_in))))
        else $error("config write did not land");
    a_ready_pulse: assert property (
        pready_out |=> !pready_out)
        else $error("ready held longer than one cycle");
    a_err_ready: assert property (
        pslverr_out |-> pready_out)
        else $error("error without ready");
    a_rdata_idle: assert property (
        !pready_out |-> prdata_out == '0)
        else $error("read data outside ready cycle");
endmodule
